// >>> psta_defines.svh
`ifndef PSTA_DEFINES_SVH
`define PSTA_DEFINES_SVH
`define PSTA_PA_W 24
`define PSTA_EA_W 16
`define PSTA_PAGE_W 8
`define PSTA_WORD_W 24
`define PSTA_MEM_AW 12
`define PSTA_SPACE_BIT 23
`define PSTA_IDX_HI 11
`define PSTA_PAGE_WORDS 1024
`define PSTA_PAGE_BYTES 3072
`define PSTA_ERASE_CNT_W 10
`define PSTA_ERASED_WORD 24'hffffff
`define PSTA_BE_LOW_WORD 3'h3
`define PSTA_BE_BYTE0 3'h1
`define PSTA_BE_BYTE1 3'h2
`define PSTA_BE_HIGH 3'h4
`define PSTA_BE_ALL 3'h7
`define PSTA_BE_NONE 3'h0
`endif

// >>> psta_pkg.sv
`include "psta_defines.svh"
package psta_pkg;
   typedef enum logic [2:0] {
      PSTA_OP_FETCH = 3'h0,
      PSTA_OP_READ_LOW = 3'h1,
      PSTA_OP_READ_HIGH = 3'h2,
      PSTA_OP_WRITE_LOW = 3'h3,
      PSTA_OP_WRITE_HIGH = 3'h4,
      PSTA_OP_WINDOW_READ = 3'h5,
      PSTA_OP_ERASE_PAGE = 3'h6,
      PSTA_OP_NONE = 3'h7
   } psta_op_t;
   typedef enum logic [1:0] {
      PSTA_ST_IDLE = 2'h0,
      PSTA_ST_READ = 2'h1,
      PSTA_ST_ERASE = 2'h2
   } psta_state_t;
   typedef logic [`PSTA_MEM_AW-1:0] psta_idx_t;
   typedef logic [`PSTA_WORD_W-1:0] psta_word_t;
endpackage : psta_pkg

// >>> psta_mem_if.sv
`timescale 1ns/1ps
interface psta_mem_if;
   import psta_pkg::*;
   psta_idx_t addr;
   logic re;
   logic we;
   logic [2:0] be;
   psta_word_t wdata;
   psta_word_t rdata;
   modport ctrl (output addr, output re, output we, output be, output wdata, input rdata);
   modport mem (input addr, input re, input we, input be, input wdata, output rdata);
endinterface : psta_mem_if

// >>> psta_mem.sv
`timescale 1ns/1ps
`include "psta_defines.svh"
module psta_mem (
   input wire logic clk,
   psta_mem_if.mem port
);
   import psta_pkg::*;
   psta_word_t array [0:(1<<`PSTA_MEM_AW)-1];
   psta_word_t rdata_q;
   // The array has no reset, like the flash it stands in for; only read data is registered.
   always_ff @(posedge clk) begin
      if (port.we) begin
         if (port.be[0]) array[port.addr][7:0] <= port.wdata[7:0];
         if (port.be[1]) array[port.addr][15:8] <= port.wdata[15:8];
         if (port.be[2]) array[port.addr][23:16] <= port.wdata[23:16];
      end
      if (port.re) begin
         rdata_q <= array[port.addr];
      end
   end
   assign port.rdata = rdata_q;
endmodule : psta_mem

// >>> psta_top.sv
`timescale 1ns/1ps
// Contract
// - A fetch address is bit 23 clear, program counter bits 22 to 1, and bit 0 zero.
// - A table address is the 8-bit table page above the 16-bit effective address.
// - Table page bit 7 clear selects user space and set selects configuration space.
// - Table operations take any byte address, aligned or not.
// - Table reads may reach configuration space as well as user space.
// - A word-mode low read returns program bits 15 to 0 unchanged.
// - A byte-mode low read returns the upper low byte when select is one, else the lower.
// - A word-mode high read returns bits 23 to 16 in the low byte and zero above.
// - A byte-mode high read returns the upper byte on select zero and zero on the phantom.
// - Program counter steps of two address successive 24-bit words.
// - Apart from fetch, only high table operations and page erase reach program bits 23 to 16.
// - The windowed view is read-only and shows only the low 16-bit word.
// - Table writes store bytes or words at an address built like a table read.
// - Erase works only on whole pages of 1024 instructions, 3072 bytes.
// - Self-programming writes program memory one word at a time.
`include "psta_defines.svh"
module psta_top (
   input wire logic clk,
   input wire logic resetn,
   input wire logic req_valid,
   input wire psta_pkg::psta_op_t req_op,
   input wire logic req_byte,
   input wire logic [`PSTA_EA_W-1:0] req_ea,
   input wire logic [`PSTA_PAGE_W-1:0] req_page,
   input wire logic [`PSTA_PA_W-2:0] req_pc,
   input wire logic [`PSTA_EA_W-1:0] req_wdata,
   output logic busy,
   output logic resp_valid,
   output logic [`PSTA_WORD_W-1:0] resp_data,
   output logic [`PSTA_PA_W-1:0] prog_addr,
   output logic cfg_space
);
   import psta_pkg::*;

   psta_mem_if mem_bus ();
   psta_mem u_mem (
      .clk(clk),
      .port(mem_bus.mem)
   );

   psta_state_t state, next_state;
   psta_op_t op_q, next_op;
   logic byte_q, next_byte;
   logic next_busy, next_resp_valid, next_cfg_space;
   logic [`PSTA_WORD_W-1:0] next_resp_data;
   logic [`PSTA_PA_W-1:0] next_prog_addr;
   logic [`PSTA_ERASE_CNT_W-1:0] erase_cnt, next_erase_cnt;

   // Only the space bit and the low word index bits are decoded, so other higher addresses alias onto the small array.
   function automatic psta_idx_t word_index(input logic [`PSTA_PA_W-1:0] a);
      word_index = {a[`PSTA_SPACE_BIT], a[`PSTA_IDX_HI:1]};
   endfunction : word_index

   function automatic logic [`PSTA_WORD_W-1:0] steer_read(input psta_op_t op, input logic bm,
         input logic sel, input psta_word_t w);
      steer_read = '0;
      case (op)
         PSTA_OP_READ_LOW: begin
            if (!bm) steer_read = {8'h00, w[15:0]};
            else if (sel) steer_read = {16'h0000, w[15:8]};
            else steer_read = {16'h0000, w[7:0]};
         end
         PSTA_OP_READ_HIGH: begin
            if (bm && sel) steer_read = '0;
            else steer_read = {16'h0000, w[23:16]};
         end
         // Window shows the low word only.
         PSTA_OP_WINDOW_READ: steer_read = {8'h00, w[15:0]};
         PSTA_OP_FETCH: steer_read = w;
         default: steer_read = '0;
      endcase
   endfunction : steer_read

   always_comb begin
      logic [`PSTA_PA_W-1:0] a;
      a = '0;
      next_state = state;
      next_op = op_q;
      next_byte = byte_q;
      next_prog_addr = prog_addr;
      next_cfg_space = cfg_space;
      next_resp_valid = 1'b0;
      next_resp_data = resp_data;
      next_erase_cnt = erase_cnt;
      mem_bus.addr = '0;
      mem_bus.re = 1'b0;
      mem_bus.we = 1'b0;
      mem_bus.be = `PSTA_BE_NONE;
      mem_bus.wdata = '0;
      case (state)
         PSTA_ST_IDLE: begin
            if (req_valid) begin
               // Fetch address from the program counter.
               if (req_op == PSTA_OP_FETCH) a = {1'b0, req_pc[`PSTA_PA_W-2:1], 1'b0};
               // Page above effective address, any byte.
               else a = {req_page, req_ea};
               next_prog_addr = a;
               // Space from the page top bit.
               next_cfg_space = a[`PSTA_SPACE_BIT];
               next_op = req_op;
               next_byte = req_byte && (req_op != PSTA_OP_FETCH);
               mem_bus.addr = word_index(a);
               case (req_op)
                  PSTA_OP_FETCH, PSTA_OP_READ_LOW, PSTA_OP_READ_HIGH, PSTA_OP_WINDOW_READ: begin
                     mem_bus.re = 1'b1;
                     next_state = PSTA_ST_READ;
                  end
                  PSTA_OP_WRITE_LOW: begin
                     // Byte select from the address, one word per request.
                     mem_bus.we = 1'b1;
                     mem_bus.wdata = {8'h00, req_wdata[15:8], req_wdata[7:0]};
                     if (!req_byte) mem_bus.be = `PSTA_BE_LOW_WORD;
                     else if (req_ea[0]) mem_bus.be = `PSTA_BE_BYTE1;
                     else mem_bus.be = `PSTA_BE_BYTE0;
                     if (req_byte && req_ea[0]) mem_bus.wdata = {8'h00, req_wdata[7:0], 8'h00};
                     next_resp_valid = 1'b1;
                  end
                  PSTA_OP_WRITE_HIGH: begin
                     // Of the writes taken in idle, only this path writes the upper byte; phantom writes drop.
                     mem_bus.we = !(req_byte && req_ea[0]);
                     mem_bus.be = (req_byte && req_ea[0]) ? `PSTA_BE_NONE : `PSTA_BE_HIGH;
                     mem_bus.wdata = {req_wdata[7:0], 16'h0000};
                     next_resp_valid = 1'b1;
                  end
                  PSTA_OP_ERASE_PAGE: begin
                     next_erase_cnt = '0;
                     next_state = PSTA_ST_ERASE;
                  end
                  default: next_resp_valid = 1'b1;
               endcase
            end
         end
         PSTA_ST_READ: begin
            next_resp_data = steer_read(op_q, byte_q, prog_addr[0], mem_bus.rdata);
            next_resp_valid = 1'b1;
            next_state = PSTA_ST_IDLE;
         end
         PSTA_ST_ERASE: begin
            // Whole-page erase, one word per cycle across 1024 words.
            mem_bus.we = 1'b1;
            mem_bus.be = `PSTA_BE_ALL;
            mem_bus.wdata = `PSTA_ERASED_WORD;
            mem_bus.addr = {prog_addr[`PSTA_SPACE_BIT], prog_addr[`PSTA_IDX_HI], erase_cnt};
            next_erase_cnt = erase_cnt + `PSTA_ERASE_CNT_W'(1);
            if (erase_cnt == `PSTA_ERASE_CNT_W'(`PSTA_PAGE_WORDS - 1)) begin
               next_resp_valid = 1'b1;
               next_state = PSTA_ST_IDLE;
            end
         end
         default: next_state = PSTA_ST_IDLE;
      endcase
      next_busy = (next_state != PSTA_ST_IDLE);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= PSTA_ST_IDLE;
         op_q <= PSTA_OP_NONE;
         byte_q <= 1'b0;
         busy <= 1'b0;
         resp_valid <= 1'b0;
         resp_data <= '0;
         prog_addr <= '0;
         cfg_space <= 1'b0;
         erase_cnt <= '0;
      end else begin
         state <= next_state;
         op_q <= next_op;
         byte_q <= next_byte;
         busy <= next_busy;
         resp_valid <= next_resp_valid;
         resp_data <= next_resp_data;
         prog_addr <= next_prog_addr;
         cfg_space <= next_cfg_space;
         erase_cnt <= next_erase_cnt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   logic [10:0] erase_len;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) erase_len <= '0;
      else if (state == PSTA_ST_ERASE) erase_len <= erase_len + 11'h001;
      else erase_len <= '0;
   end

   sequence s_take(psta_op_t o);
      state == PSTA_ST_IDLE && req_valid && req_op == o;
   endsequence
   sequence s_read_step(psta_op_t o, logic b);
      state == PSTA_ST_READ && op_q == o && byte_q == b;
   endsequence

   fetch_addr_a: assert property (s_take(PSTA_OP_FETCH) |=>
      prog_addr == {1'b0, $past(req_pc[22:1]), 1'b0}) else $error("fetch address wrong");
   table_addr_a: assert property (
      s_take(PSTA_OP_READ_LOW) or s_take(PSTA_OP_WRITE_HIGH) |=>
      prog_addr == {$past(req_page), $past(req_ea)} && cfg_space == $past(req_page[7]))
      else $error("table address wrong");
   low_word_a: assert property (s_read_step(PSTA_OP_READ_LOW, 1'b0) |=>
      resp_valid && resp_data == {8'h00, $past(mem_bus.rdata[15:0])}) else $error("low word bad");
   low_byte_a: assert property (s_read_step(PSTA_OP_READ_LOW, 1'b1) |=>
      resp_data[7:0] == ($past(prog_addr[0]) ? $past(mem_bus.rdata[15:8]) :
      $past(mem_bus.rdata[7:0])) && resp_data[23:8] == 16'h0000) else $error("low byte bad");
   high_word_a: assert property (s_read_step(PSTA_OP_READ_HIGH, 1'b0) |=>
      resp_data == {16'h0000, $past(mem_bus.rdata[23:16])}) else $error("high word bad");
   phantom_zero_a: assert property (
      s_read_step(PSTA_OP_READ_HIGH, 1'b1) ##0 prog_addr[0] |=>
      resp_valid && resp_data == '0) else $error("phantom byte not zero");
   high_only_a: assert property (
      mem_bus.we && mem_bus.be[2] && state == PSTA_ST_IDLE |->
      req_op == PSTA_OP_WRITE_HIGH) else $error("upper byte written by a low operation");
   window_ro_a: assert property (s_take(PSTA_OP_WINDOW_READ) |-> !mem_bus.we ##1
      !mem_bus.we ##1 resp_valid && resp_data[23:16] == 8'h00) else $error("window not read-only");
   erase_page_a: assert property (
      state == PSTA_ST_ERASE && next_state == PSTA_ST_IDLE |->
      erase_len == 11'(`PSTA_PAGE_WORDS - 1)) else $error("erase length wrong");
   one_word_a: assert property (mem_bus.we && state == PSTA_ST_IDLE |=>
      resp_valid && state == PSTA_ST_IDLE && !busy) else $error("more than one word per write");
   byte_sel_a: assert property (s_take(PSTA_OP_WRITE_LOW) ##0 req_byte |->
      mem_bus.be == (req_ea[0] ? `PSTA_BE_BYTE1 : `PSTA_BE_BYTE0))
      else $error("byte select wrong");
endmodule : psta_top

// >>> psta_core_model.sv
`timescale 1ns/1ps
`include "psta_defines.svh"
module psta_core_model (
   input wire logic clk,
   input wire logic busy,
   input wire logic resp_valid,
   output logic req_valid,
   output psta_pkg::psta_op_t req_op,
   output logic req_byte,
   output logic [`PSTA_EA_W-1:0] req_ea,
   output logic [`PSTA_PAGE_W-1:0] req_page,
   output logic [`PSTA_PA_W-2:0] req_pc,
   output logic [`PSTA_EA_W-1:0] req_wdata
);
   import psta_pkg::*;
   initial begin
      req_valid = 1'b0;
      req_op = PSTA_OP_NONE;
      req_byte = 1'b0;
      req_ea = 16'h0000;
      req_page = 8'h00;
      req_pc = 23'h000000;
      req_wdata = 16'h0000;
   end
   task automatic issue(input psta_op_t op, input logic bm, input logic [15:0] ea,
         input logic [7:0] pg, input logic [22:0] pc, input logic [15:0] wd, output int cyc);
      @(negedge clk);
      while (busy !== 1'b0) @(negedge clk);
      req_op = op;
      req_byte = bm;
      req_ea = ea;
      req_page = pg;
      req_pc = pc;
      req_wdata = wd;
      req_valid = 1'b1;
      @(posedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      // The released effective address, write data and program counter flip so that a stale value cannot pass for a held one.
      req_ea = ~req_ea;
      req_wdata = ~req_wdata;
      req_pc = ~req_pc;
      cyc = 1;
      while (resp_valid !== 1'b1 && cyc < 1100) begin
         @(negedge clk);
         cyc++;
      end
   endtask : issue
endmodule : psta_core_model

// >>> program_space_table_access_test.sv
`timescale 1ns/1ps
`include "psta_defines.svh"
module program_space_table_access_test;
   import psta_pkg::*;
   logic clk, resetn, req_valid, req_byte, busy, resp_valid, cfg_space;
   psta_op_t req_op;
   logic [15:0] req_ea, req_wdata;
   logic [7:0] req_page;
   logic [22:0] req_pc;
   logic [23:0] resp_data, prog_addr;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int cyc;
   psta_top dut (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_op(req_op),
      .req_byte(req_byte), .req_ea(req_ea), .req_page(req_page), .req_pc(req_pc),
      .req_wdata(req_wdata), .busy(busy), .resp_valid(resp_valid),
      .resp_data(resp_data), .prog_addr(prog_addr), .cfg_space(cfg_space));
   psta_core_model core (.clk(clk), .busy(busy), .resp_valid(resp_valid),
      .req_valid(req_valid), .req_op(req_op), .req_byte(req_byte), .req_ea(req_ea),
      .req_page(req_page), .req_pc(req_pc), .req_wdata(req_wdata));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // The erase alone costs over a thousand cycles, so the ceiling leaves ample room.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         close_out();
      end
   end
   task close_out;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask : chk
   task acc(input psta_op_t op, input logic bm, input logic [15:0] ea, input logic [7:0] pg,
         input logic [15:0] wd, input logic [23:0] exp);
      logic wr;
      wr = (op == PSTA_OP_WRITE_LOW || op == PSTA_OP_WRITE_HIGH || op == PSTA_OP_NONE);
      core.issue(op, bm, ea, pg, 23'h000000, wd, cyc);
      chk("latency", wr ? 24'h000001 : 24'h000002, 24'(cyc));
      chk("prog_addr", {pg, ea}, prog_addr);
      chk("cfg_space", {23'h000000, pg[7]}, {23'h000000, cfg_space});
      if (!wr) begin
         chk("resp_data", exp, resp_data);
      end
   endtask : acc
   task s_fetch;
      acc(PSTA_OP_WRITE_LOW, 1'b0, 16'h0124, 8'h00, 16'hbeef, 24'h000000);
      acc(PSTA_OP_WRITE_HIGH, 1'b0, 16'h0124, 8'h00, 16'h005a, 24'h000000);
      acc(PSTA_OP_WRITE_LOW, 1'b0, 16'h0126, 8'h00, 16'h1234, 24'h000000);
      acc(PSTA_OP_WRITE_HIGH, 1'b0, 16'h0126, 8'h00, 16'h00c3, 24'h000000);
      core.issue(PSTA_OP_FETCH, 1'b0, 16'h0000, 8'h00, 23'h400125, 16'h0000, cyc);
      chk("fetch addr", 24'h400124, prog_addr);
      chk("fetch data", 24'h5abeef, resp_data);
      core.issue(PSTA_OP_FETCH, 1'b0, 16'h0000, 8'h00, 23'h400127, 16'h0000, cyc);
      chk("next fetch addr", 24'h400126, prog_addr);
      chk("next fetch data", 24'hc31234, resp_data);
   endtask : s_fetch
   task s_low;
      acc(PSTA_OP_WRITE_LOW, 1'b0, 16'h0200, 8'h80, 16'ha55a, 24'h000000);
      acc(PSTA_OP_READ_LOW, 1'b0, 16'h0201, 8'h80, 16'h0000, 24'h00a55a);
      acc(PSTA_OP_READ_LOW, 1'b0, 16'h0200, 8'h80, 16'h0000, 24'h00a55a);
      acc(PSTA_OP_READ_LOW, 1'b1, 16'h0201, 8'h80, 16'h0000, 24'h0000a5);
      acc(PSTA_OP_READ_LOW, 1'b1, 16'h0200, 8'h80, 16'h0000, 24'h00005a);
   endtask : s_low
   task s_high;
      acc(PSTA_OP_WRITE_HIGH, 1'b0, 16'h0200, 8'h80, 16'hff3c, 24'h000000);
      acc(PSTA_OP_READ_HIGH, 1'b0, 16'h0200, 8'h80, 16'h0000, 24'h00003c);
      acc(PSTA_OP_READ_HIGH, 1'b1, 16'h0200, 8'h80, 16'h0000, 24'h00003c);
      acc(PSTA_OP_READ_HIGH, 1'b1, 16'h0201, 8'h80, 16'h0000, 24'h000000);
      acc(PSTA_OP_READ_LOW, 1'b0, 16'h0200, 8'h80, 16'h0000, 24'h00a55a);
   endtask : s_high
   task s_window;
      acc(PSTA_OP_WINDOW_READ, 1'b0, 16'h0200, 8'h80, 16'h1111, 24'h00a55a);
      acc(PSTA_OP_NONE, 1'b0, 16'h0200, 8'h80, 16'h2222, 24'h000000);
      acc(PSTA_OP_READ_LOW, 1'b0, 16'h0200, 8'h80, 16'h0000, 24'h00a55a);
      acc(PSTA_OP_READ_HIGH, 1'b0, 16'h0200, 8'h80, 16'h0000, 24'h00003c);
   endtask : s_window
   task s_bytewr;
      acc(PSTA_OP_WRITE_LOW, 1'b1, 16'h0201, 8'h80, 16'h3377, 24'h000000);
      acc(PSTA_OP_READ_LOW, 1'b0, 16'h0200, 8'h80, 16'h0000, 24'h00775a);
      acc(PSTA_OP_WRITE_HIGH, 1'b1, 16'h0201, 8'h80, 16'h0011, 24'h000000);
      acc(PSTA_OP_READ_HIGH, 1'b0, 16'h0200, 8'h80, 16'h0000, 24'h00003c);
   endtask : s_bytewr
   task s_erase;
      // Busy must stand through the erase, so it is sampled while the request is still open.
      fork
         core.issue(PSTA_OP_ERASE_PAGE, 1'b0, 16'h0a00, 8'h80, 23'h0, 16'h0, cyc);
         begin
            repeat (3) @(negedge clk);
            chk("erase busy", 24'h000001, {23'h000000, busy});
         end
      join
      chk("erase latency", 24'd1025, 24'(cyc));
      acc(PSTA_OP_READ_LOW, 1'b0, 16'h0800, 8'h80, 16'h0000, 24'h00ffff);
      acc(PSTA_OP_READ_HIGH, 1'b0, 16'h0ffe, 8'h80, 16'h0000, 24'h0000ff);
      acc(PSTA_OP_READ_LOW, 1'b0, 16'h0200, 8'h80, 16'h0000, 24'h00775a);
   endtask : s_erase
   initial begin
      resetn = 1'b0;
      repeat (10) @(posedge clk);
      chk("reset outputs", 24'h000000, {21'h000000, resp_valid, busy, cfg_space});
      @(negedge clk);
      resetn = 1'b1;
      s_fetch();
      s_low();
      s_high();
      s_window();
      s_bytewr();
      s_erase();
      close_out();
   end
endmodule : program_space_table_access_test
